// [hw/pmc_dflt.sv]
`timescale 1ns/1ps
module pmc_dflt import pmc_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Image from the SMBus or EEPROM loader
  input wire logic ld_valid,
  input wire pmc_dflt_t ld_data,
  // Current image
  output pmc_dflt_t dflt_q
);
  logic loaded_q;

  // Host has no path in here at all
  always_ff @(posedge mclk) begin
    if (srst) begin
      dflt_q <= PMC_DFLT_RST; // R3 R4 R5 R6 R14
    end else if (ld_valid) begin
      dflt_q <= ld_data; // R7
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      loaded_q <= 1'h0;
    end else if (ld_valid) begin
      loaded_q <= 1'h1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  dflt_reset_a: assert property (!loaded_q && !ld_valid |=> dflt_q == PMC_DFLT_RST) // R4
    else $error("default image differs from reset value before any load");
  dflt_load_a: assert property (ld_valid |=> dflt_q == $past(ld_data)) // R7
    else $error("loader image not taken");
endmodule : pmc_dflt

// [hw/pmc_pstate.sv]
`timescale 1ns/1ps
module pmc_pstate import pmc_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Host write of the state field, and the skip flag from the default image
  input wire logic wr_en,
  input wire pmc_pstate_t wr_state,
  input wire logic no_soft_rst,
  // State and reset pulses
  output pmc_pstate_t pstate_q,
  output logic hot_rst_q,
  output logic int_rst_q
);
  logic wake_d;

  assign wake_d = wr_en && pstate_q == PMC_D3HOT && wr_state == PMC_D0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pstate_q <= PMC_D0; // R8
    end else if (wr_en) begin
      pstate_q <= wr_state; // R8
    end
  end

  // External link reset pin is never driven from here
  always_ff @(posedge mclk) begin
    if (srst) begin
      hot_rst_q <= 1'h0;
      int_rst_q <= 1'h0;
    end else begin
      hot_rst_q <= wake_d; // R9
      int_rst_q <= wake_d && !no_soft_rst; // R10
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  sequence d3_to_d0_s;
    pstate_q == PMC_D3HOT ##0 wr_en && wr_state == PMC_D0;
  endsequence

  hot_reset_a: assert property (d3_to_d0_s |=> hot_rst_q ##1 !hot_rst_q) // R9
    else $error("hot reset pulse missing after D3hot to D0");
  hot_cause_a: assert property (hot_rst_q |-> // R9
    $past(pstate_q) == PMC_D3HOT && pstate_q == PMC_D0)
    else $error("hot reset without D3hot to D0");
  int_reset_a: assert property (int_rst_q == (hot_rst_q && !$past(no_soft_rst))) // R10
    else $error("internal reset does not follow the skip flag");
endmodule : pmc_pstate

// [hw/pmc_regs.sv]
`timescale 1ns/1ps
module pmc_regs import pmc_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration access
  input wire pmc_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata_q,
  output logic cfg_ack_q,
  // Function number strap
  input wire logic [1:0] fn_id,
  // Default image from SMBus or EEPROM loader
  input wire logic ld_valid,
  input wire pmc_dflt_t ld_data,
  // Power management events
  input wire logic pme_event,
  output logic pme_req_q,
  // Power state and resets
  output pmc_pstate_t pstate_q,
  output logic hot_reset_q,
  output logic int_reset_q
);
  pmc_dflt_t dflt_q;

  logic hit_cap;
  logic hit_ctl;
  logic hit_mctl;
  logic hit_madr;
  logic hit_mdat;

  logic wr_ctl;
  logic wr_mctl;
  logic wr_madr;
  logic wr_mdat;

  logic has_pme;

  logic pme_en_q;
  logic [3:0] dsel_q;
  logic pme_st_q;

  logic msi_en_q;
  logic [2:0] mme_q;
  logic [29:0] madr_q;
  logic [15:0] mdat_q;

  logic [31:0] madr_mrg;
  logic [31:0] mdat_mrg;
  logic [31:0] rd_d;

  // Address decode; byte offset bits are ignored
  assign hit_cap = pmc_hit(cfg_req, PMC_OFF_CAP);
  assign hit_ctl = pmc_hit(cfg_req, PMC_OFF_CTL);
  assign hit_mctl = pmc_hit(cfg_req, PMC_OFF_MCTL);
  assign hit_madr = pmc_hit(cfg_req, PMC_OFF_MADR);
  assign hit_mdat = pmc_hit(cfg_req, PMC_OFF_MDAT);

  // Capability word has no write path at all
  assign wr_ctl = cfg_req.wr && hit_ctl; // R7
  assign wr_mctl = cfg_req.wr && hit_mctl;
  assign wr_madr = cfg_req.wr && hit_madr;
  assign wr_mdat = cfg_req.wr && hit_mdat;

  assign has_pme = fn_id != PMC_FN_NO_PME; // R12

  pmc_dflt u_dflt (
    .mclk(mclk),
    .srst(srst),
    .ld_valid(ld_valid),
    .ld_data(ld_data),
    .dflt_q(dflt_q)
  );

  pmc_pstate u_pstate (
    .mclk(mclk),
    .srst(srst),
    .wr_en(wr_ctl && cfg_req.be[0]), // R8
    .wr_state(pmc_pstate_t'(cfg_req.wdata[PMC_PST +: 2])),
    .no_soft_rst(dflt_q.no_soft_rst),
    .pstate_q(pstate_q),
    .hot_rst_q(hot_reset_q),
    .int_rst_q(int_reset_q)
  );

  // Event enable and data select live in byte 1
  always_ff @(posedge mclk) begin
    if (srst) begin
      pme_en_q <= 1'h0; // R11
      dsel_q <= 4'h0;
    end else if (wr_ctl && cfg_req.be[1]) begin
      pme_en_q <= cfg_req.wdata[PMC_PMEEN]; // R11
      dsel_q <= cfg_req.wdata[PMC_DSEL +: 4];
    end
  end

  // New event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      pme_st_q <= 1'h0; // R12
    end else if (!has_pme) begin
      pme_st_q <= 1'h0; // R12
    end else if (pme_event) begin
      pme_st_q <= 1'h1; // R12
    end else if (wr_ctl && cfg_req.be[1] && cfg_req.wdata[PMC_PMEST]) begin
      pme_st_q <= 1'h0; // R12
    end
  end

  // Request only while the host allows it
  always_ff @(posedge mclk) begin
    if (srst) begin
      pme_req_q <= 1'h0;
    end else begin
      pme_req_q <= pme_st_q && pme_en_q; // R11
    end
  end

  // Message interrupt fields are storage only, nothing is ever sent
  always_ff @(posedge mclk) begin
    if (srst) begin
      msi_en_q <= 1'h0; // R15
      mme_q <= 3'h0;
    end else if (wr_mctl && cfg_req.be[2]) begin
      msi_en_q <= cfg_req.wdata[PMC_MEN]; // R15
      mme_q <= cfg_req.wdata[PMC_MME +: 3];
    end
  end

  assign madr_mrg = pmc_merge({madr_q, 2'h0}, cfg_req.wdata, cfg_req.be);
  assign mdat_mrg = pmc_merge({16'h0000, mdat_q}, cfg_req.wdata, cfg_req.be);

  always_ff @(posedge mclk) begin
    if (srst) begin
      madr_q <= 30'h0;
    end else if (wr_madr) begin
      madr_q <= madr_mrg[31:PMC_MADR]; // R15
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mdat_q <= 16'h0000;
    end else if (wr_mdat) begin
      mdat_q <= mdat_mrg[15:0]; // R15
    end
  end

  // Read image; every bit not placed here reads zero
  always_comb begin
    rd_d = 32'h0; // R2 R16
    if (hit_cap) begin
      rd_d[PMC_REV +: 3] = PMC_REV_VAL; // R1
      rd_d[PMC_DSI] = dflt_q.dsi; // R3
      rd_d[PMC_AUX +: 3] = dflt_q.aux; // R4
      rd_d[PMC_D1] = dflt_q.d1; // R5
      rd_d[PMC_D2] = dflt_q.d2; // R5
      rd_d[PMC_PSUP +: 5] = dflt_q.pme_sup; // R6
    end else if (hit_ctl) begin
      rd_d[PMC_PST +: 2] = pstate_q; // R8
      rd_d[PMC_NSR] = dflt_q.no_soft_rst; // R10
      rd_d[PMC_PMEEN] = pme_en_q;
      rd_d[PMC_DSEL +: 4] = dsel_q;
      rd_d[PMC_PMEST] = pme_st_q && has_pme; // R12
    end else if (hit_mctl) begin
      rd_d[7:0] = PMC_MSI_ID; // R13
      rd_d[PMC_MNEXT +: 8] = dflt_q.msi_next; // R14
      rd_d[PMC_MEN] = msi_en_q;
      rd_d[PMC_MME +: 3] = mme_q; // R15
    end else if (hit_madr) begin
      rd_d[31:PMC_MADR] = madr_q; // R15
    end else if (hit_mdat) begin
      rd_d[15:0] = mdat_q;
    end
  end

  // One-cycle answer to every access, mapped or not
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_rdata_q <= 32'h0;
      cfg_ack_q <= 1'h0;
    end else begin
      cfg_rdata_q <= cfg_req.rd ? rd_d : 32'h0;
      cfg_ack_q <= cfg_req.rd || cfg_req.wr;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  sequence rd_cap_s;
    cfg_req.rd && hit_cap;
  endsequence

  sequence rd_ctl_s;
    cfg_req.rd && hit_ctl;
  endsequence

  cap_rev_a: assert property (rd_cap_s |=> cfg_ack_q && cfg_rdata_q[18:16] == 3'h3) // R1
    else $error("revision field not 011b");

  // Bits 23:22 of the capabilities word carry the aux current, so only the control word
  hw_zero_a: assert property (rd_cap_s or rd_ctl_s |=> cfg_rdata_q[19] == 1'h0 && // R2
    (!$past(hit_ctl) || cfg_rdata_q[23:16] == 8'h0))
    else $error("hardwired zero bit reads one");

  cap_dflt_a: assert property (rd_cap_s ##0 dflt_q == PMC_DFLT_RST // R6
    |=> cfg_rdata_q[31:21] == 11'h7FE)
    else $error("capability defaults wrong");

  ro_hold_a: assert property (cfg_req.wr && hit_cap && !ld_valid |=> $stable(dflt_q)) // R7
    else $error("host write changed a read-only default");

  pstate_wr_a: assert property (wr_ctl && cfg_req.be[0] // R8
    |=> pstate_q == $past(cfg_req.wdata[1:0]))
    else $error("power state write not taken");

  pme_req_a: assert property (pme_req_q == $past(pme_st_q && pme_en_q)) // R11
    else $error("event request does not follow status and enable");

  pme_set_a: assert property (pme_event && has_pme |=> pme_st_q) // R12
    else $error("event lost");

  pme_fn2_a: assert property (!has_pme ##1 !has_pme |-> !pme_st_q) // R12
    else $error("event status set for function without it");

  msi_id_a: assert property (cfg_req.rd && hit_mctl // R13
    |=> cfg_rdata_q[7:0] == 8'h05 && cfg_rdata_q[15:8] == $past(dflt_q.msi_next))
    else $error("message capability header wrong");

  msi_ro_a: assert property (cfg_req.rd && hit_mctl |=> cfg_rdata_q[31:23] == 9'h0 && // R15
    cfg_rdata_q[19:17] == 3'h0)
    else $error("message control read-only bits not zero");

  madr_low_a: assert property (cfg_req.rd && hit_madr |=> cfg_rdata_q[1:0] == 2'h0) // R15
    else $error("message address low bits not zero");

  mdat_hi_a: assert property (cfg_req.rd && hit_mdat |=> cfg_rdata_q[31:16] == 16'h0) // R16
    else $error("message data upper half not zero");

  ctl_rsv_a: assert property (rd_ctl_s |=> cfg_rdata_q[2] == 1'h0 && // R16
    cfg_rdata_q[7:4] == 4'h0 && cfg_rdata_q[31:24] == 8'h0)
    else $error("control word reserved bits not zero");
endmodule : pmc_regs

// [pkg/pmc_pkg.sv]
// Summary of operation
// R1 - The revision field in bits 18:16 of the capabilities word always reads 011b.
// R2 - Capabilities bit 19 and bridge extension bits 22 and 23 always read zero.
// R3 - The device-specific-initialization bit 21 reads zero by default.
// R4 - The auxiliary current field in bits 24:22 comes out of reset as 111b.
// R5 - The D1 support bit 25 and D2 support bit 26 read one by default.
// R6 - The event support field in bits 31:27 reads 11111b by default.
// R7 - Read-only defaults are replaced only by the SMBus or EEPROM loader, never by the host.
// R8 - The power state in bits 1:0 is host-writable, reports the state and resets to D0.
// R9 - Writing D0 while in D3hot causes a hot reset without touching the external reset pin.
// R10 - Bit 3 resets to one; when it is zero the D3hot to D0 step also resets internally.
// R11 - Bit 8 is a host-writable event enable, reset to zero, that permits event requests.
// R12 - Bit 15 flags a pending event for functions 0 and 1, is write-one-to-clear, zero for 2.
// R13 - The message-interrupt capability ID byte always reads 05h.
// R14 - The message-interrupt next pointer resets to E0h and is loadable by the loader.
// R15 - MSI enable, message enable, address and data are writable and inert; the rest reads 0.
// R16 - Host writes to read-only or reserved bits are ignored and reserved bits read zero.
package pmc_pkg;
  // Dword offsets in configuration space
  localparam logic [7:0] PMC_OFF_CAP = 8'h80;
  localparam logic [7:0] PMC_OFF_CTL = 8'h84;
  localparam logic [7:0] PMC_OFF_MCTL = 8'h8C;
  localparam logic [7:0] PMC_OFF_MADR = 8'h90;
  localparam logic [7:0] PMC_OFF_MDAT = 8'h94;
  // Capabilities word fields
  localparam int PMC_REV = 16;
  localparam int PMC_DSI = 21;
  localparam int PMC_AUX = 22;
  localparam int PMC_D1 = 25;
  localparam int PMC_D2 = 26;
  localparam int PMC_PSUP = 27;
  localparam logic [2:0] PMC_REV_VAL = 3'h3;
  // Control and status word fields
  localparam int PMC_PST = 0;
  localparam int PMC_NSR = 3;
  localparam int PMC_PMEEN = 8;
  localparam int PMC_DSEL = 9;
  localparam int PMC_PMEST = 15;
  // Message interrupt fields
  localparam logic [7:0] PMC_MSI_ID = 8'h05;
  localparam int PMC_MNEXT = 8;
  localparam int PMC_MEN = 16;
  localparam int PMC_MME = 20;
  localparam int PMC_MADR = 2;
  // Function that has no event status
  localparam logic [1:0] PMC_FN_NO_PME = 2'h2;

  typedef enum logic [1:0] {PMC_D0, PMC_D1S, PMC_D2S, PMC_D3HOT} pmc_pstate_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pmc_cfg_req_t;

  typedef struct packed {
    logic dsi;
    logic [2:0] aux;
    logic d1;
    logic d2;
    logic [4:0] pme_sup;
    logic no_soft_rst;
    logic [7:0] msi_next;
  } pmc_dflt_t;

  localparam pmc_dflt_t PMC_DFLT_RST = '{dsi: 1'h0, aux: 3'h7, d1: 1'h1, d2: 1'h1,
    pme_sup: 5'h1F, no_soft_rst: 1'h1, msi_next: 8'hE0};

  function automatic logic [31:0] pmc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      pmc_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : pmc_merge

  function automatic logic pmc_hit(input pmc_cfg_req_t r, input logic [7:0] off);
    return r.addr[7:2] == off[7:2];
  endfunction : pmc_hit
endpackage : pmc_pkg

// [verif/pmc_host_model.sv]
`timescale 1ns/1ps
module pmc_host_model import pmc_pkg::*; (
  // Clock
  input wire logic mclk,
  // Configuration request and answer
  output pmc_cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_ack_q
);
  initial cfg_req = '0;

  // One access, reads and writes alike; the answer is taken with the ack
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge mclk);
    #1;
    cfg_req = '{wr: wr, rd: !wr, addr: a, be: be, wdata: wd};
    @(posedge mclk);
    #1;
    ok = cfg_ack_q;
    rd = cfg_rdata_q;
    // Idle lines flip so that stale data is never mistaken for a live word
    cfg_req = '{wr: 1'h0, rd: 1'h0, addr: ~a, be: ~be, wdata: ~wd};
  endtask : xfer
endmodule : pmc_host_model

// [verif/pmc_regs_tb_top.sv]
`timescale 1ns/1ps
module pmc_regs_tb_top import pmc_pkg::*;;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic [1:0] fn_id = 2'h0;
  logic ld_valid = 1'h0;
  pmc_dflt_t ld_data = '0;
  logic pme_event = 1'h0;
  pmc_cfg_req_t cfg_req;
  logic [31:0] cfg_rdata_q;
  logic cfg_ack_q;
  logic pme_req_q;
  pmc_pstate_t pstate_q;
  logic hot_reset_q;
  logic int_reset_q;
  int miscompares = 0;
  int check_count = 0;

  always #2.5 mclk = ~mclk;

  pmc_host_model host (.mclk(mclk), .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q),
    .cfg_ack_q(cfg_ack_q));

  pmc_regs uut (.mclk(mclk), .srst(srst), .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q),
    .cfg_ack_q(cfg_ack_q), .fn_id(fn_id), .ld_valid(ld_valid), .ld_data(ld_data),
    .pme_event(pme_event), .pme_req_q(pme_req_q), .pstate_q(pstate_q),
    .hot_reset_q(hot_reset_q), .int_reset_q(int_reset_q));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    host.xfer(1'h0, a, 4'h0, 32'h0, d, ok);
    chk($sformatf("ack %h", a), 32'(ok), 32'h1);
    chk($sformatf("reg %h", a), d, exp);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    logic ok;
    host.xfer(1'h1, a, be, wd, d, ok);
  endtask : wr

  task automatic pulse_event();
    @(posedge mclk);
    #1;
    pme_event = 1'h1;
    @(posedge mclk);
    #1;
    pme_event = 1'h0;
    @(posedge mclk);
    #1;
  endtask : pulse_event

  task automatic t_reset();
    rd_chk(8'h80, 32'hFFC30000);
    rd_chk(8'h84, 32'h00000008);
    rd_chk(8'h8C, 32'h0000E005);
    rd_chk(8'h90, 32'h00000000);
    rd_chk(8'h94, 32'h00000000);
    rd_chk(8'h98, 32'h00000000);
  endtask : t_reset

  task automatic t_write_all();
    wr(8'h80, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h80, 32'hFFC30000);
    wr(8'h84, 4'hF, 32'hFFFFFFFF);
    chk("hot from d0", 32'(hot_reset_q), 32'h0);
    rd_chk(8'h84, 32'h00001F0B);
    chk("pstate", 32'(pstate_q), 32'h3);
    wr(8'h8C, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h8C, 32'h0071E005);
    wr(8'h90, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h90, 32'hFFFFFFFC);
    wr(8'h94, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h94, 32'h0000FFFF);
    wr(8'h98, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h98, 32'h00000000);
  endtask : t_write_all

  task automatic t_hot_reset();
    wr(8'h84, 4'h1, 32'h0);
    chk("hot", 32'(hot_reset_q), 32'h1);
    chk("int skip", 32'(int_reset_q), 32'h0);
    chk("pstate d0", 32'(pstate_q), 32'h0);
    wr(8'h84, 4'h1, 32'h1);
    wr(8'h84, 4'h1, 32'h0);
    chk("hot from d1", 32'(hot_reset_q), 32'h0);
    rd_chk(8'h84, 32'h00001F08);
  endtask : t_hot_reset

  task automatic t_load();
    @(posedge mclk);
    #1;
    ld_data = '{dsi: 1'h1, aux: 3'h2, d1: 1'h0, d2: 1'h0, pme_sup: 5'h0A,
      no_soft_rst: 1'h0, msi_next: 8'hA0};
    ld_valid = 1'h1;
    @(posedge mclk);
    #1;
    ld_valid = 1'h0;
    rd_chk(8'h80, 32'h50A30000);
    rd_chk(8'h8C, 32'h0071A005);
    rd_chk(8'h84, 32'h00001F00);
    wr(8'h84, 4'h1, 32'h3);
    wr(8'h84, 4'h1, 32'h0);
    chk("hot", 32'(hot_reset_q), 32'h1);
    chk("int", 32'(int_reset_q), 32'h1);
  endtask : t_load

  task automatic t_event();
    pulse_event();
    chk("req", 32'(pme_req_q), 32'h1);
    rd_chk(8'h84, 32'h00009F00);
    wr(8'h84, 4'h2, 32'h00009F00);
    rd_chk(8'h84, 32'h00001F00);
    chk("req clr", 32'(pme_req_q), 32'h0);
    fn_id = 2'h2;
    pulse_event();
    rd_chk(8'h84, 32'h00001F00);
    chk("req fn2", 32'(pme_req_q), 32'h0);
    fn_id = 2'h0;
    wr(8'h84, 4'h2, 32'h00001E00);
    pulse_event();
    chk("req off", 32'(pme_req_q), 32'h0);
    rd_chk(8'h84, 32'h00009E00);
  endtask : t_event

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (3) @(posedge mclk);
    #1;
    srst = 1'h0;
    t_reset();
    t_write_all();
    t_hot_reset();
    t_load();
    t_event();
    end_sim();
  end

  // Whole run is about 80 cycles; this cuts a hang well past that
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
endmodule : pmc_regs_tb_top
